//--- hw/logic_cells_pkg.sv
package logic_cells_pkg;

    localparam int unsigned CELLS      = 4;
    localparam int unsigned EXT_INPUTS = 8;
    localparam int unsigned STAT_INPUTS = 8;
    localparam int unsigned SRC_W      = 5;
    localparam int unsigned MODE_W     = 5;

    // source index map: 0 const low, 1 const high, ext, status, cells
    localparam logic [SRC_W-1:0] SRC_LOW  = 5'h00;
    localparam logic [SRC_W-1:0] SRC_HIGH = 5'h01;
    localparam int unsigned SRC_EXT_BASE  = 2;
    localparam int unsigned SRC_STAT_BASE = SRC_EXT_BASE + EXT_INPUTS;
    localparam int unsigned SRC_CELL_BASE = SRC_STAT_BASE + STAT_INPUTS;
    localparam int unsigned SRC_COUNT     = SRC_CELL_BASE + CELLS;

    typedef enum logic [MODE_W-1:0] {
        MODE_OFF    = 5'h00,
        MODE_AND    = 5'h01,
        MODE_OR     = 5'h02,
        MODE_XOR    = 5'h03,
        MODE_LATCH  = 5'h0A,
        MODE_TOGGLE = 5'h14,
        MODE_DFF    = 5'h1E
    } cell_mode_e;

    // register word index per cell: mode, first source, second source
    localparam int unsigned REG_PER_CELL = 4;
    localparam int unsigned REG_MODE     = 0;
    localparam int unsigned REG_SRC1     = 1;
    localparam int unsigned REG_SRC2     = 2;
    localparam logic [7:0]  ADDR_STATUS  = 8'h40;
    localparam logic [31:0] RESET_WORD   = 32'h0000_0000;

endpackage

//--- hw/logic_cell.sv
`timescale 1ns/1ps
module logic_cell
(
    input  wire logic                                  clk_i,
    input  wire logic                                  rst_i,
    input  wire logic                                  step_i,
    input  wire logic [logic_cells_pkg::MODE_W-1:0]    mode_i,
    input  wire logic                                  first_cell_input_i,
    input  wire logic                                  second_cell_input_i,
    output logic                                       out_o
);

    logic state_q;
    logic state_d;
    logic prev1_q;
    logic prev2_q;
    logic rise1;
    logic rise2;

    assign rise1 = first_cell_input_i & ~prev1_q;
    assign rise2 = second_cell_input_i & ~prev2_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev1_q <= 1'b0;
            prev2_q <= 1'b0;
        end
        else if (step_i)
        begin
            prev1_q <= first_cell_input_i;
            prev2_q <= second_cell_input_i;
        end
    end

    // next stored state, visible to later cells within the same step
    always_comb
    begin
        state_d = state_q;
        if (step_i)
        begin
            case (mode_i)
                logic_cells_pkg::MODE_LATCH:
                begin
                    if (second_cell_input_i)
                        state_d = 1'b0;
                    else if (first_cell_input_i)
                        state_d = 1'b1;
                    else
                        state_d = state_q;
                end
                logic_cells_pkg::MODE_TOGGLE:
                begin
                    if (rise1)
                        state_d = ~state_q;
                end
                logic_cells_pkg::MODE_DFF:
                begin
                    if (rise2)
                        state_d = first_cell_input_i;
                end
                default:
                    state_d = state_q;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_q <= 1'b0;
        else
            state_q <= state_d;
    end

    always_comb
    begin
        case (mode_i)
            logic_cells_pkg::MODE_OFF:    out_o = 1'b0;
            logic_cells_pkg::MODE_AND:    out_o = first_cell_input_i & second_cell_input_i;
            logic_cells_pkg::MODE_OR:     out_o = first_cell_input_i | second_cell_input_i;
            logic_cells_pkg::MODE_XOR:    out_o = first_cell_input_i ^ second_cell_input_i;
            logic_cells_pkg::MODE_LATCH,
            logic_cells_pkg::MODE_TOGGLE,
            logic_cells_pkg::MODE_DFF:    out_o = state_d;
            default:                      out_o = 1'b0;
        endcase
    end

    a_off_low: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_i == logic_cells_pkg::MODE_OFF |-> !out_o)
        else $error("off cell output not low");
    a_latch_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        step_i && mode_i == logic_cells_pkg::MODE_LATCH && second_cell_input_i
        |=> !state_q)
        else $error("latch clear lost");
    a_toggle_flip: assert property (@(posedge clk_i) disable iff (rst_i)
        step_i && mode_i == logic_cells_pkg::MODE_TOGGLE && rise1
        |=> state_q != $past(state_q))
        else $error("toggle missed");
    a_toggle_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        step_i && mode_i == logic_cells_pkg::MODE_TOGGLE && !rise1
        |=> $stable(state_q))
        else $error("toggle without rising edge");
    a_dff_take: assert property (@(posedge clk_i) disable iff (rst_i)
        step_i && mode_i == logic_cells_pkg::MODE_DFF && rise2
        |=> state_q == $past(first_cell_input_i))
        else $error("data not captured");
    a_dff_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        step_i && mode_i == logic_cells_pkg::MODE_DFF && !rise2
        |=> $stable(state_q))
        else $error("data changed without clock edge");
    a_seq_visible: assert property (@(posedge clk_i) disable iff (rst_i)
        step_i && (mode_i == logic_cells_pkg::MODE_LATCH || mode_i == logic_cells_pkg::MODE_TOGGLE
        || mode_i == logic_cells_pkg::MODE_DFF) |=> state_q == $past(out_o))
        else $error("new state not shown in its step");
    c_toggle: cover property (@(posedge clk_i) step_i && mode_i == logic_cells_pkg::MODE_TOGGLE
        && rise1);
    c_dff: cover property (@(posedge clk_i) step_i && mode_i == logic_cells_pkg::MODE_DFF
        && rise2);
    c_latch_both: cover property (@(posedge clk_i) step_i
        && mode_i == logic_cells_pkg::MODE_LATCH && first_cell_input_i && second_cell_input_i);

endmodule

//--- hw/logic_cells.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module logic_cells
#(
    parameter int unsigned STEP_DIV = 10
)
(
    input  wire logic                                        clk_i,
    input  wire logic                                        rst_i,
    input  wire logic [logic_cells_pkg::EXT_INPUTS-1:0]      ext_in_i,
    input  wire logic [logic_cells_pkg::STAT_INPUTS-1:0]     status_in_i,
    input  wire logic                                        cyc_i,
    input  wire logic                                        stb_i,
    input  wire logic                                        we_i,
    input  wire logic [7:0]                                  adr_i,
    input  wire logic [3:0]                                  sel_i,
    input  wire logic [31:0]                                 dat_i,
    output logic [31:0]                                      dat_o,
    output logic                                             ack_o,
    output logic [logic_cells_pkg::CELLS-1:0]                cell_out_o
);

    localparam int unsigned N  = logic_cells_pkg::CELLS;
    localparam int unsigned SW = logic_cells_pkg::SRC_W;
    localparam int unsigned MW = logic_cells_pkg::MODE_W;

    ////////////////////////////////////////////////////////////////////////////
    // step divider

    logic [15:0] div_q;
    logic        step;

    assign step = (div_q == 16'(STEP_DIV - 1));

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            div_q <= 16'h0000;
        else if (step)
            div_q <= 16'h0000;
        else
            div_q <= div_q + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [logic_cells_pkg::EXT_INPUTS-1:0]  ext_m_q;
    logic [logic_cells_pkg::EXT_INPUTS-1:0]  ext_s_q;
    logic [logic_cells_pkg::STAT_INPUTS-1:0] stat_m_q;
    logic [logic_cells_pkg::STAT_INPUTS-1:0] stat_s_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_m_q  <= '0;
            ext_s_q  <= '0;
            stat_m_q <= '0;
            stat_s_q <= '0;
        end
        else
        begin
            ext_m_q  <= ext_in_i;
            ext_s_q  <= ext_m_q;
            stat_m_q <= status_in_i;
            stat_s_q <= stat_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic [MW-1:0] mode_q [N];
    logic [SW-1:0] src1_q [N];
    logic [SW-1:0] src2_q [N];

    logic       wr;
    logic [5:0] word;
    logic [1:0] cell_idx;
    logic [1:0] field;
    logic       in_cells;

    assign word     = adr_i[7:2];
    assign cell_idx = word[3:2];
    assign field    = word[1:0];
    assign in_cells = (word[5:4] == 2'b00);
    assign wr       = cyc_i & stb_i & we_i & ~ack_o & sel_i[0] & in_cells;

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_cfg
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    mode_q[g] <= MW'(logic_cells_pkg::RESET_WORD);
                    src1_q[g] <= SW'(logic_cells_pkg::RESET_WORD);
                    src2_q[g] <= SW'(logic_cells_pkg::RESET_WORD);
                end
                else if (wr && cell_idx == 2'(g))
                begin
                    if (field == 2'(logic_cells_pkg::REG_MODE))
                        mode_q[g] <= dat_i[MW-1:0];
                    if (field == 2'(logic_cells_pkg::REG_SRC1))
                        src1_q[g] <= dat_i[SW-1:0];
                    if (field == 2'(logic_cells_pkg::REG_SRC2))
                        src2_q[g] <= dat_i[SW-1:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // source selection and cell chain

    logic [logic_cells_pkg::SRC_COUNT-1:0] pool [N+1];
    logic [N-1:0]                          cell_out;
    logic [N-1:0]                          in1;
    logic [N-1:0]                          in2;
    logic [N-1:0]                          out_q;

    function automatic logic pick
    (
        input logic [logic_cells_pkg::SRC_COUNT-1:0] p,
        input logic [SW-1:0]                         s
    );
        logic r;
        r = 1'b0;
        if (32'(s) < logic_cells_pkg::SRC_COUNT)
            r = p[s];
        return r;
    endfunction

    generate
        for (g = 0; g < N; g++)
        begin : g_cell
            // pool g holds outputs of cells below g from this step, others stored
            assign in1[g] = pick(pool[g], src1_q[g]);
            assign in2[g] = pick(pool[g], src2_q[g]);

            logic_cell u_cell
            (
                .clk_i               (clk_i),
                .rst_i               (rst_i),
                .step_i              (step),
                .mode_i              (mode_q[g]),
                .first_cell_input_i  (in1[g]),
                .second_cell_input_i (in2[g]),
                .out_o               (cell_out[g])
            );
        end
    endgenerate

    always_comb
    begin
        for (int i = 0; i <= N; i++)
        begin
            pool[i] = '0;
            pool[i][logic_cells_pkg::SRC_HIGH] = 1'b1;
            pool[i][logic_cells_pkg::SRC_EXT_BASE +: logic_cells_pkg::EXT_INPUTS] = ext_s_q;
            pool[i][logic_cells_pkg::SRC_STAT_BASE +: logic_cells_pkg::STAT_INPUTS] = stat_s_q;
            for (int k = 0; k < N; k++)
                pool[i][logic_cells_pkg::SRC_CELL_BASE + k] = (k < i) ? cell_out[k] : out_q[k];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            out_q <= '0;
        else if (step)
            out_q <= cell_out;
    end

    assign cell_out_o = out_q;

    ////////////////////////////////////////////////////////////////////////////
    // wishbone acknowledge (reads and writes) and read side

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i & stb_i & ~ack_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else if (cyc_i && stb_i && !we_i && !ack_o)
        begin
            dat_o <= 32'h0000_0000;
            if (adr_i == logic_cells_pkg::ADDR_STATUS)
                dat_o <= 32'(out_q);
            else if (in_cells)
            begin
                if (field == 2'(logic_cells_pkg::REG_MODE))
                    dat_o <= 32'(mode_q[cell_idx]);
                else if (field == 2'(logic_cells_pkg::REG_SRC1))
                    dat_o <= 32'(src1_q[cell_idx]);
                else if (field == 2'(logic_cells_pkg::REG_SRC2))
                    dat_o <= 32'(src2_q[cell_idx]);
            end
        end
    end

    a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held two cycles");
    a_chain_same: assert property (@(posedge clk_i) disable iff (rst_i)
        step && src1_q[1] == 5'(logic_cells_pkg::SRC_CELL_BASE) |-> in1[1] == cell_out[0])
        else $error("chain not same step");
    a_step_period: assert property (@(posedge clk_i) disable iff (rst_i)
        step |=> !step)
        else $error("step too frequent");
    a_out_stable: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(step) && !$past(rst_i) |-> $stable(cell_out_o))
        else $error("output moved off step");
    c_chain: cover property (@(posedge clk_i) step && cell_out[0] && in1[1]);
    c_read_status: cover property (@(posedge clk_i) ack_o && !we_i
        && adr_i == logic_cells_pkg::ADDR_STATUS);

endmodule

//--- verification/input_source.sv
`timescale 1ns/1ps
// far side: digital inputs and drive status sources, changed on the clock edge
module input_source
(
    input  wire logic       clk_i,
    input  wire logic [7:0] ext_req_i,
    input  wire logic [7:0] stat_req_i,
    output logic      [7:0] ext_o,
    output logic      [7:0] status_o
);
    always_ff @(posedge clk_i)
    begin
        ext_o    <= ext_req_i;
        status_o <= stat_req_i;
    end
endmodule

//--- verification/tb_logic_cells.sv
`timescale 1ns/1ps
module tb_logic_cells;
    localparam int unsigned DIV = 4;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic [7:0]  ext_req  = 8'h00;
    logic [7:0]  stat_req = 8'h00;
    logic        cyc_i    = 1'b0;
    logic        stb_i    = 1'b0;
    logic        we_i     = 1'b0;
    logic [7:0]  adr_i    = 8'h00;
    logic [3:0]  sel_i    = 4'h0;
    logic [31:0] dat_i    = 32'h0000_0000;
    logic [7:0]  ext_in;
    logic [7:0]  status_in;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [3:0]  cell_out_o;
    logic [31:0] notes[$];
    logic [31:0] note_v;
    logic [4:0]  modes[8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h0A, 5'h14, 5'h1E, 5'h07};
    logic        a, b, c, s0, s1, pa, pb, q0;
    int          bad_count  = 0;
    int          n_compared = 0;
    int          cycles     = 0;

    always #50 clk_i = ~clk_i;

    input_source input_source_inst
    (
        .clk_i      (clk_i),
        .ext_req_i  (ext_req),
        .stat_req_i (stat_req),
        .ext_o      (ext_in),
        .status_o   (status_in)
    );

    logic_cells #(.STEP_DIV(DIV)) logic_cells_inst
    (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ext_in_i    (ext_in),
        .status_in_i (status_in),
        .cyc_i       (cyc_i),
        .stb_i       (stb_i),
        .we_i        (we_i),
        .adr_i       (adr_i),
        .sel_i       (sel_i),
        .dat_i       (dat_i),
        .dat_o       (dat_o),
        .ack_o       (ack_o),
        .cell_out_o  (cell_out_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a_, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a_;
        dat_i <= d;
        sel_i <= s;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a_, input logic [31:0] d);
        bus(1'b1, a_, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] a_, input logic [31:0] e);
        notes.push_back(e);
        bus(1'b0, a_, 32'h0000_0000, 4'hF);
    endtask

    // reference next output of a cell
    function automatic logic nxt(logic [4:0] m, logic i1, logic i2, logic p1, logic p2,
                                 logic q);
        case (m)
            logic_cells_pkg::MODE_OFF:    nxt = 1'b0;
            logic_cells_pkg::MODE_AND:    nxt = i1 & i2;
            logic_cells_pkg::MODE_OR:     nxt = i1 | i2;
            logic_cells_pkg::MODE_XOR:    nxt = i1 ^ i2;
            logic_cells_pkg::MODE_LATCH:  nxt = i2 ? 1'b0 : (i1 | q);
            logic_cells_pkg::MODE_TOGGLE: nxt = (i1 & ~p1) ? ~q : q;
            logic_cells_pkg::MODE_DFF:    nxt = (i2 & ~p2) ? i1 : q;
            default:                      nxt = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // result watcher: each read answer against the oldest note
    always @(posedge clk_i)
        if (cyc_i && stb_i && !we_i && ack_o === 1'b1)
        begin
            note_v = notes.pop_front();
            check(dat_o, note_v);
            if (adr_i == 8'h40)
                check({28'h0, cell_out_o}, note_v);
        end

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            report_and_stop();
        end
    end

    initial
    begin
        void'($urandom(87460));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h40, 32'h0000_0000);
        rd(8'h7C, 32'h0000_0000);
        foreach (modes[i])
        begin
            @(posedge clk_i);
            rst_i    <= 1'b1;
            ext_req  <= 8'h00;
            stat_req <= 8'h00;
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            rd(8'h40, 32'h0000_0000);
            wr(8'h04, 32'h0000_0002);
            wr(8'h08, 32'h0000_0003);
            wr(8'h00, {27'h0, modes[i]});
            wr(8'h14, 32'h0000_0012);
            wr(8'h18, 32'h0000_000A);
            wr(8'h10, 32'h0000_0001);
            wr(8'h24, 32'h0000_0001);
            wr(8'h28, 32'h0000_0001);
            bus(1'b1, 8'h20, 32'h0000_0001, 4'hE);
            wr(8'h34, 32'h0000_0004);
            wr(8'h38, 32'h0000_000B);
            wr(8'h30, 32'h0000_0002);
            rd(8'h00, {27'h0, modes[i]});
            rd(8'h20, 32'h0000_0000);
            pa = 1'b0;
            pb = 1'b0;
            q0 = 1'b0;
            repeat (8)
            begin
                a  = 1'($urandom);
                b  = 1'($urandom);
                c  = 1'($urandom);
                s0 = 1'($urandom);
                s1 = 1'($urandom);
                ext_req  <= {5'h00, c, b, a};
                stat_req <= {6'h00, s1, s0};
                repeat (3 * DIV + 4) @(posedge clk_i);
                q0 = nxt(modes[i], a, b, pa, pb, q0);
                pa = a;
                pb = b;
                rd(8'h40, {28'h0, c | s1, 1'b0, q0 & s0, q0});
            end
        end
        report_and_stop();
    end
endmodule
